// ### hdl/drs_pkg.sv
// constants shared by the dual rail sequence supervisor controller
package drs_pkg;
  localparam int DRS_ADDR_W = 8;
  localparam int DRS_DATA_W = 32;
  localparam int DRS_CNT_W = 32;
  localparam int DRS_EV_W = 6;

  // register byte offsets
  localparam logic [DRS_ADDR_W-1:0] DRS_CTRL_OFS = 8'h00;
  localparam logic [DRS_ADDR_W-1:0] DRS_STAT_OFS = 8'h04;
  localparam logic [DRS_ADDR_W-1:0] DRS_EVT_OFS = 8'h08;
  localparam logic [DRS_ADDR_W-1:0] DRS_MASK_OFS = 8'h0C;
  localparam logic [DRS_ADDR_W-1:0] DRS_RTIME_OFS = 8'h10;

  // control fields
  localparam int DRS_CTRL_ENABLE = 0;
  localparam int DRS_CTRL_ORDER = 1;
  localparam int DRS_CTRL_TRIG_A = 2;
  localparam int DRS_CTRL_TRIG_B = 3;
  localparam int DRS_CTRL_PG_TO_B = 4;
  localparam int DRS_CTRL_W = 5;
  localparam logic [DRS_CTRL_W-1:0] DRS_CTRL_RST = 5'h02;

  // live status fields
  localparam int DRS_STAT_PG = 0;
  localparam int DRS_STAT_RESET_REL = 1;
  localparam int DRS_STAT_TIMING = 2;
  localparam int DRS_STAT_DELAY_MET = 3;
  localparam int DRS_STAT_W = 4;

  // event fields
  localparam int DRS_EV_PG_RISE = 0;
  localparam int DRS_EV_PG_FALL = 1;
  localparam int DRS_EV_RST_REL = 2;
  localparam int DRS_EV_RST_ASSERT = 3;
  localparam int DRS_EV_EARLY_REL = 4;
  localparam int DRS_EV_LATE_REL = 5;
  localparam logic [DRS_EV_W-1:0] DRS_MASK_RST = 6'h00;

  // reset release delay
  localparam int DRS_REL_DELAY_MS = 120;
  localparam int DRS_CLK_KHZ = 250000;
  localparam logic [DRS_CNT_W-1:0] DRS_REL_DELAY_CYC = DRS_CNT_W'(DRS_REL_DELAY_MS * DRS_CLK_KHZ);
  localparam logic [DRS_CNT_W-1:0] DRS_CNT_ONE = 32'h0000_0001;
  localparam logic [DRS_CNT_W-1:0] DRS_CNT_MAX = 32'hFFFF_FFFF;
  // a release later than twice the delay is reported as late
  localparam int DRS_LATE_FACTOR = 2;
endpackage : drs_pkg

// ### hdl/drs_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module drs_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule // drs_sync
`default_nettype wire

// ### hdl/drs_timer.sv
// cycle counter that times how long release conditions have held
`timescale 1ns/1ps
`default_nettype none
module drs_timer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic [drs_pkg::DRS_CNT_W-1:0] limit,
  // results
  output logic [drs_pkg::DRS_CNT_W-1:0] count,
  output logic limit_met
);
  import drs_pkg::*;

  logic [DRS_CNT_W-1:0] cnt_q;
  logic [DRS_CNT_W-1:0] cnt_d;
  logic met_q;
  logic met_d;

  always_comb
  begin
    // any loss of the conditions restarts the whole delay
    cnt_d = '0;
    met_d = 1'b0;
    if (run)
    begin
      cnt_d = (cnt_q == DRS_CNT_MAX) ? cnt_q : cnt_q + DRS_CNT_ONE;
      met_d = (cnt_d >= limit);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      met_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      met_q <= met_d;
    end
  end

  assign count = cnt_q;
  assign limit_met = met_q;
endmodule // drs_timer
`default_nettype wire

// ### hdl/drs_ctrl.sv
// host-side controller for a dual rail regulator with reset supervisor
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - pull-up assumed on good flag
// - unused manual triggers held high
// - reset is active-low open drain, pulled up
// - good flag may drive a manual trigger
module drs_ctrl #(
  parameter logic [drs_pkg::DRS_CNT_W-1:0] REL_DELAY_CYCLES = drs_pkg::DRS_REL_DELAY_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [drs_pkg::DRS_ADDR_W-1:0] paddr,
  input wire logic [drs_pkg::DRS_DATA_W-1:0] pwdata,
  output logic [drs_pkg::DRS_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // device control pins
  output logic sleep_n_hi,
  output logic order_select,
  output logic manual_trigger_a_n_o,
  output logic manual_trigger_a_n_oe,
  output logic manual_trigger_b_n_o,
  output logic manual_trigger_b_n_oe,
  // device status pins, open drain with board pull-ups
  input wire logic rail_one_good_flag,
  input wire logic device_reset_n
);
  import drs_pkg::*;

  // pin synchronisers
  logic pg_s;
  logic rst_n_s;

  drs_sync #(
    .WIDTH(2),
    .RST_VAL(2'h0)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_i({rail_one_good_flag, device_reset_n}),
    .sync_o({pg_s, rst_n_s})
  );

  // register state
  logic [DRS_CTRL_W-1:0] ctrl_q;
  logic [DRS_CTRL_W-1:0] ctrl_d;
  logic [DRS_EV_W-1:0] ev_q;
  logic [DRS_EV_W-1:0] ev_d;
  logic [DRS_EV_W-1:0] mask_q;
  logic [DRS_EV_W-1:0] mask_d;
  logic [DRS_CNT_W-1:0] rtime_q;
  logic [DRS_CNT_W-1:0] rtime_d;
  logic pg_q;
  logic pg_d;
  logic rstn_q;
  logic rstn_d;
  logic [DRS_DATA_W-1:0] prdata_q;
  logic [DRS_DATA_W-1:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;
  logic irq_q;
  logic irq_d;

  // pin state
  logic sleep_q;
  logic sleep_d;
  logic order_q;
  logic order_d;
  // triggers held at their active-low pin levels
  logic trig_a_n_q;
  logic trig_a_n_d;
  logic trig_b_n_q;
  logic trig_b_n_d;
  logic trig_oe_q;
  logic trig_oe_d;

  // timer
  logic host_ok;
  logic [DRS_CNT_W-1:0] tcount;
  logic tmet;
  logic [DRS_CNT_W-1:0] late_limit;

  function automatic logic addr_hit(input logic [DRS_ADDR_W-1:0] a);
    addr_hit = (a == DRS_CTRL_OFS) || (a == DRS_STAT_OFS) || (a == DRS_EVT_OFS) ||
               (a == DRS_MASK_OFS) || (a == DRS_RTIME_OFS);
  endfunction

  // conditions this controller can see: enabled, no trigger pulled
  assign host_ok = !sleep_q && trig_a_n_q && trig_b_n_q;
  assign late_limit = DRS_CNT_W'(REL_DELAY_CYCLES * DRS_LATE_FACTOR);

  drs_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(host_ok && !rst_n_s),
    .limit(REL_DELAY_CYCLES),
    .count(tcount),
    .limit_met(tmet)
  );

  // apb access qualifiers
  logic setup;
  logic access;
  logic wr_acc;
  logic rd_evt;

  assign setup = psel && !penable;
  assign access = psel && penable && pready_q;
  assign wr_acc = access && pwrite && addr_hit(paddr);
  assign rd_evt = access && !pwrite && (paddr == DRS_EVT_OFS);

  // register file
  always_comb
  begin
    logic [DRS_EV_W-1:0] ev_set;
    ev_set = '0;
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    rtime_d = rtime_q;
    pg_d = pg_s;
    rstn_d = rst_n_s;
    if (wr_acc && paddr == DRS_CTRL_OFS)
    begin
      ctrl_d = pwdata[DRS_CTRL_W-1:0];
    end
    if (wr_acc && paddr == DRS_MASK_OFS)
    begin
      mask_d = pwdata[DRS_EV_W-1:0];
    end
    // good flag is high only when released and pulled up
    ev_set[DRS_EV_PG_RISE] = pg_s && !pg_q;
    ev_set[DRS_EV_PG_FALL] = !pg_s && pg_q;
    ev_set[DRS_EV_RST_REL] = rst_n_s && !rstn_q;
    ev_set[DRS_EV_RST_ASSERT] = !rst_n_s && rstn_q;
    // release before the delay could have run is a device fault
    ev_set[DRS_EV_EARLY_REL] = rst_n_s && !rstn_q && host_ok && !tmet;
    // reset still held long after host conditions: rail two or supply not good
    ev_set[DRS_EV_LATE_REL] = !rst_n_s && host_ok && (tcount == late_limit);
    if (rst_n_s && !rstn_q)
    begin
      rtime_d = tcount;
    end
    // a hardware set wins over the read clear
    ev_d = (rd_evt ? '0 : ev_q) | ev_set;
    irq_d = |(ev_q & mask_q);
  end

  // apb slave: one wait-free access phase, read data latched at setup
  always_comb
  begin
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    pready_d = setup;
    if (setup)
    begin
      prdata_d = '0;
      pslverr_d = !addr_hit(paddr);
      unique case (paddr)
        DRS_CTRL_OFS: prdata_d[DRS_CTRL_W-1:0] = ctrl_q;
        DRS_STAT_OFS:
        begin
          prdata_d[DRS_STAT_PG] = pg_q;
          prdata_d[DRS_STAT_RESET_REL] = rstn_q;
          prdata_d[DRS_STAT_TIMING] = host_ok && !rstn_q;
          prdata_d[DRS_STAT_DELAY_MET] = tmet;
        end
        DRS_EVT_OFS: prdata_d[DRS_EV_W-1:0] = ev_q;
        DRS_MASK_OFS: prdata_d[DRS_EV_W-1:0] = mask_q;
        DRS_RTIME_OFS: prdata_d = rtime_q;
        default: prdata_d = '0;
      endcase
    end
  end

  // device pins, kept at pin level so every output leaves a flop
  always_comb
  begin
    // high on the sleep pin shuts both rails down
    sleep_d = !ctrl_q[DRS_CTRL_ENABLE];
    // high gives rail two first, low gives rail one first
    order_d = ctrl_q[DRS_CTRL_ORDER];
    // released triggers are driven high, never left floating
    trig_a_n_d = !ctrl_q[DRS_CTRL_TRIG_A];
    // good flag routed only while enabled, so sleep cannot pin reset low
    trig_b_n_d = !(ctrl_q[DRS_CTRL_TRIG_B] ||
                   (ctrl_q[DRS_CTRL_PG_TO_B] && ctrl_q[DRS_CTRL_ENABLE] && !pg_q));
    trig_oe_d = 1'b1;
  end

  // register file state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= DRS_CTRL_RST;
      ev_q <= '0;
      mask_q <= DRS_MASK_RST;
      rtime_q <= '0;
      pg_q <= 1'b0;
      rstn_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      ev_q <= ev_d;
      mask_q <= mask_d;
      rtime_q <= rtime_d;
      pg_q <= pg_d;
      rstn_q <= rstn_d;
      irq_q <= irq_d;
    end
  end

  // apb answer state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // pin state: device off and triggers released while in reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sleep_q <= 1'b1;
      order_q <= 1'b1;
      trig_a_n_q <= 1'b1;
      trig_b_n_q <= 1'b1;
      trig_oe_q <= 1'b1;
    end
    else
    begin
      sleep_q <= sleep_d;
      order_q <= order_d;
      trig_a_n_q <= trig_a_n_d;
      trig_b_n_q <= trig_b_n_d;
      trig_oe_q <= trig_oe_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign sleep_n_hi = sleep_q;
  assign order_select = order_q;
  // triggers are always driven: low when pulled, high when released
  assign manual_trigger_a_n_o = trig_a_n_q;
  assign manual_trigger_a_n_oe = trig_oe_q;
  assign manual_trigger_b_n_o = trig_b_n_q;
  assign manual_trigger_b_n_oe = trig_oe_q;
endmodule // drs_ctrl
`default_nettype wire

// ### tb/drs_ctrl_chk.sv
// assertion checker for the dual rail sequence controller
`timescale 1ns/1ps
`default_nettype none
module drs_ctrl_chk
  import drs_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [DRS_ADDR_W-1:0] paddr,
  input wire logic [DRS_DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // device pins
  input wire logic sleep_n_hi,
  input wire logic order_select,
  input wire logic manual_trigger_a_n_o,
  input wire logic manual_trigger_a_n_oe,
  input wire logic manual_trigger_b_n_oe
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ctrl;
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == DRS_CTRL_OFS;
  apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer after setup");
  ready_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  err_unmapped_a: assert property (pready && paddr > DRS_RTIME_OFS |-> pslverr) else $error("unmapped accepted");
  // pins follow the control register one edge after it is written
  sleep_write_a: assert property (wr_ctrl |-> ##2 sleep_n_hi == !$past(pwdata[DRS_CTRL_ENABLE], 2))
    else $error("sleep pin wrong");
  order_write_a: assert property (wr_ctrl |-> ##2 order_select == $past(pwdata[DRS_CTRL_ORDER], 2))
    else $error("order pin wrong");
  trig_write_a: assert property (wr_ctrl |-> ##2 manual_trigger_a_n_o == !$past(pwdata[DRS_CTRL_TRIG_A], 2))
    else $error("trigger pin wrong");
  pins_hold_a: assert property (!wr_ctrl && !$past(wr_ctrl) |=> $stable(sleep_n_hi) && $stable(order_select))
    else $error("pins moved");
  trig_drive_a: assert property (manual_trigger_a_n_oe && manual_trigger_b_n_oe)
    else $error("trigger left floating");
endmodule // drs_ctrl_chk
bind drs_ctrl drs_ctrl_chk chk_u (.*);
`default_nettype wire

// ### tb/drs_dev_model.sv
// behavioural model of the regulator's sequencing and reset pins
`timescale 1ns/1ps
`default_nettype none
module drs_dev_model #(
  parameter int DELAY = 50,
  parameter int DEGLITCH = 4
) (
  // clock
  input wire logic clk,
  // control pins
  input wire logic sleep_n_hi,
  input wire logic order_select,
  input wire logic trig_a_n,
  input wire logic trig_b_n,
  // analog conditions set by the bench
  input wire logic supply_ok,
  input wire logic overload2,
  // open drain pull-downs
  output logic good_low,
  output logic reset_low
);
  logic r1 = 1'b0;
  logic r2 = 1'b0;
  // rail one as the good comparator sees it, after the falling deglitch
  logic r1_seen = 1'b0;
  int dg = 0;
  int cnt = 0;
  // one cycle per ramp keeps the order visible
  always @(posedge clk)
  begin
    r2 <= !sleep_n_hi && !overload2 && (order_select || r1);
    r1 <= !sleep_n_hi && (order_select ? r2 : 1'b1);
    // a rising rail is seen at once, a falling one only after the deglitch
    if (r1)
    begin
      r1_seen <= 1'b1;
      dg <= 0;
    end
    else if (dg < DEGLITCH)
      dg <= dg + 1;
    else
      r1_seen <= 1'b0;
    if (supply_ok && trig_a_n && trig_b_n && r2)
      cnt <= (cnt < DELAY) ? cnt + 1 : cnt;
    else
      cnt <= 0;
  end
  assign good_low = !r1_seen;
  assign reset_low = cnt < DELAY;
endmodule // drs_dev_model
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the dual rail sequence controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import drs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, irq, sleep_n_hi, order_select, ev;
  logic ta_o, ta_oe, tb_o, tb_oe, pg_low, rst_low, sup_ok, ovl, pready, pslverr;
  logic [DRS_ADDR_W-1:0] paddr;
  logic [DRS_DATA_W-1:0] pwdata, prdata, rv;
  int n_errors = 0;
  int cmp_count = 0;
  // board pull-ups on every open drain or released line
  wire logic ta_n = ta_oe ? ta_o : 1'b1;
  wire logic tb_n = tb_oe ? tb_o : 1'b1;
  wire logic pg = !pg_low;
  wire logic rst_n = !rst_low;
  drs_ctrl #(.REL_DELAY_CYCLES(32'h0000_0032)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .sleep_n_hi(sleep_n_hi), .order_select(order_select),
    .manual_trigger_a_n_o(ta_o), .manual_trigger_a_n_oe(ta_oe), .manual_trigger_b_n_o(tb_o),
    .manual_trigger_b_n_oe(tb_oe), .rail_one_good_flag(pg), .device_reset_n(rst_n));
  drs_dev_model #(.DELAY(50)) dev_u (.clk(pclk), .sleep_n_hi(sleep_n_hi), .order_select(order_select),
    .trig_a_n(ta_n), .trig_b_n(tb_n), .supply_ok(sup_ok), .overload2(ovl), .good_low(pg_low), .reset_low(rst_low));
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = !pclk;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for ready under a bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      close_out();
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
    for (int i = 0; i < 200; i++)
    begin
      apb(1'b0, DRS_STAT_OFS, 32'h0);
      if ((rv & m) === v)
        return;
    end
    n_errors++;
    close_out();
  endtask
  task automatic settle();
    repeat (2) @(negedge pclk);
  endtask
  initial
  begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    close_out();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    sup_ok = 1'b1;
    ovl = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, DRS_CTRL_OFS, 32'h0);
    chk(rv, 32'h0000_0002);
    apb(1'b0, DRS_MASK_OFS, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({rv[30:0], ev}, 32'h0000_0001);
    $display("test reset_values done");
    apb(1'b1, DRS_CTRL_OFS, 32'h0000_0003);
    settle();
    chk({31'h0, sleep_n_hi}, 32'h0);
    wait_stat(32'h3, 32'h3);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, DRS_MASK_OFS, 32'h0000_003F);
    settle();
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, DRS_EVT_OFS, 32'h0);
    chk(rv & 32'h5, 32'h5);
    apb(1'b0, DRS_EVT_OFS, 32'h0);
    chk(rv, 32'h0);
    settle();
    chk({31'h0, irq}, 32'h0);
    $display("test enable_irq done");
    @(posedge pclk);
    ovl <= 1'b1;
    wait_stat(32'h3, 32'h0);
    apb(1'b0, DRS_EVT_OFS, 32'h0);
    chk(rv & 32'hA, 32'hA);
    ovl <= 1'b0;
    wait_stat(32'h3, 32'h3);
    $display("test overload done");
    apb(1'b1, DRS_CTRL_OFS, 32'h0000_0007);
    wait_stat(32'h2, 32'h0);
    apb(1'b1, DRS_CTRL_OFS, 32'h0000_0003);
    wait_stat(32'h2, 32'h2);
    apb(1'b0, DRS_RTIME_OFS, 32'h0);
    chk({31'h0, rv >= 32'h32}, 32'h1);
    apb(1'b0, DRS_EVT_OFS, 32'h0);
    sup_ok <= 1'b0;
    wait_stat(32'h2, 32'h0);
    repeat (110) @(posedge pclk);
    apb(1'b0, DRS_EVT_OFS, 32'h0);
    chk(rv & 32'h28, 32'h28);
    sup_ok <= 1'b1;
    wait_stat(32'h2, 32'h2);
    $display("test manual_supply done");
    apb(1'b1, DRS_CTRL_OFS, 32'h0);
    wait_stat(32'h3, 32'h0);
    apb(1'b1, DRS_CTRL_OFS, 32'h0000_0001);
    settle();
    chk({31'h0, order_select}, 32'h0);
    wait_stat(32'h3, 32'h3);
    apb(1'b1, DRS_CTRL_OFS, 32'h0);
    settle();
    chk({31'h0, sleep_n_hi}, 32'h1);
    wait_stat(32'h3, 32'h0);
    $display("test order_sleep done");
    apb(1'b1, DRS_CTRL_OFS, 32'h0000_0013);
    settle();
    chk({31'h0, tb_n}, 32'h0);
    wait_stat(32'h3, 32'h3);
    chk({31'h0, tb_n}, 32'h1);
    ovl <= 1'b1;
    wait_stat(32'h3, 32'h0);
    chk({31'h0, tb_n}, 32'h0);
    ovl <= 1'b0;
    wait_stat(32'h3, 32'h3);
    $display("test good_to_trigger done");
    close_out();
  end
endmodule // tb
`default_nettype wire
